// *** twp_params.svh ***
// named offsets, bit positions, reset values and codes of the firing driver
`ifndef TWP_PARAMS_SVH
`define TWP_PARAMS_SVH

`define TWP_ADR_W      8
`define TWP_ADR_MODE   8'h00
`define TWP_ADR_WHI    8'h04
`define TWP_ADR_WLO    8'h08
`define TWP_ADR_CNT    8'h0c
`define TWP_ADR_PSL    8'h10
`define TWP_ADR_PSH    8'h14
`define TWP_ADR_GCF    8'h18
`define TWP_ADR_STAT   8'h1c

`define TWP_BIT_POL    0
`define TWP_BIT_PHASE  3
`define TWP_BIT_CLOCK_SOURCE_SELECT   4
`define TWP_BIT_RUN    5
`define TWP_BIT_SECOND_MAINS_SOURCE   6
`define TWP_BIT_REL    7
`define TWP_MASK_HI    5
`define TWP_MASK_LO    3

`define TWP_INT_NONE   3'h0
`define TWP_INT_RISE_A 3'h1
`define TWP_INT_FALL_B 3'h2
`define TWP_INT_BOTH_A 3'h3
`define TWP_INT_PULSE  3'h4

`define TWP_MODE_RST   8'h00
`define TWP_WLO_RST    8'h00
`define TWP_WHI_RST    8'h00
`define TWP_LAST_HALF  4'hf
`define TWP_ONE16      16'h0001
`define TWP_PRE_W      16

`endif

// *** twp_pkg.sv ***
// types shared by the firing driver modules
`include "twp_params.svh"
package twp_pkg;

    typedef struct packed {
        logic                   cyc;
        logic                   stb;
        logic                   we;
        logic [`TWP_ADR_W-1:0]  adr;
        logic [3:0]             sel;
        logic [31:0]            dat;
    } twp_wb_req_s;

    typedef enum logic [3:0] {
        TWP_IDLE  = 4'h1,
        TWP_DELAY = 4'h2,
        TWP_PULSE = 4'h4,
        TWP_DONE  = 4'h8
    } twp_state_e;

    typedef struct packed {
        logic a_q;
        logic b_q;
    } twp_edge_s;

    typedef struct packed {
        logic [`TWP_PRE_W-1:0] cnt;
    } twp_pre_s;

    typedef struct packed {
        logic [7:0]  mode;
        logic [7:0]  whi;
        logic [7:0]  wlo;
        logic [7:0]  cnt;
        logic [7:0]  psl;
        logic [7:0]  psh;
        logic [7:0]  gcf;
        logic [15:0] width;
        twp_state_e  state;
        logic [7:0]  delay;
        logic [15:0] half;
        logic [3:0]  halves;
        logic        level;
        logic        out;
        logic        irq;
        logic        ack;
        logic [31:0] rdat;
    } twp_core_s;

endpackage

// *** twp_edge.sv ***
// mains sync edge detector with optional tie of the second input to the first
`timescale 1ns/10ps
`default_nettype none
module twp_edge (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic a_i,
    input  wire logic b_i,
    input  wire logic tie_i,
    output logic      rise_a_o,
    output logic      fall_a_o,
    output logic      fall_b_o
);
    twp_pkg::twp_edge_s s_r;
    twp_pkg::twp_edge_s s_nxt;
    logic               b_eff;

    always_comb begin
        b_eff     = tie_i ? a_i : b_i;
        s_nxt.a_q = a_i;
        s_nxt.b_q = b_eff;
        rise_a_o  = a_i & ~s_r.a_q;
        fall_a_o  = ~a_i & s_r.a_q;
        fall_b_o  = ~b_eff & s_r.b_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end
endmodule
`default_nettype wire

// *** twp_prescaler.sv ***
// divide-by-(N+1) prescaler, restartable at each half-period
`timescale 1ns/10ps
`default_nettype none
`include "twp_params.svh"
module twp_prescaler (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire logic                  clear_i,
    input  wire logic                  event_i,
    input  wire logic [`TWP_PRE_W-1:0] div_i,
    output logic                       tick_o
);
    twp_pkg::twp_pre_s s_r;
    twp_pkg::twp_pre_s s_nxt;

    always_comb begin
        s_nxt  = s_r;
        tick_o = ~clear_i & event_i & (s_r.cnt == div_i);
        if (clear_i) begin
            s_nxt.cnt = '0;
        end else if (event_i) begin
            s_nxt.cnt = tick_o ? '0 : s_r.cnt + `TWP_ONE16;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end
endmodule
`default_nettype wire

// *** twp_driver.sv ***
// triac phase-angle firing driver with its wishbone register file
// How it works
// - delay T1 lasts firing count times (prescaler value plus one) master clocks
// - after T1 exactly eight firing pulses go out in this half-period
// - each pulse half lasts pulse width value master clocks
// - width value is sixteen bits, high byte over low byte register
// - high and low halves of every pulse are equal, duty one half
// - new width only taken while peripheral is held in reset
// - mode bit 0 low gives positive pulses, high gives negative
// - irq choice: none, rise a, fall b, both edges a, first pulse
// - zero width keeps output inactive but still raises pulse event after T1
// - events always made inside; three-bit mask field picks the one passed
// - mode bit 3 high picks phase mode, the only mode that runs; bits 2 and 1 unused
// - mode bit 4 picks master clock or mains a as prescaler source
// - mode bit 5 stops or starts the generator
// - mode bit 6 ties mains b to mains a, freeing the b pin
// - mode bit 7 low holds the peripheral in reset
// - mode register and width low byte reset to zero
// - T1 grows in direct proportion to the firing count
`timescale 1ns/10ps
`default_nettype none
`include "twp_params.svh"
module twp_driver (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    input  wire twp_pkg::twp_wb_req_s wb_i,
    output logic                      ack_o,
    output logic [31:0]               dat_o,
    input  wire logic                 mains_sync_a_i,
    input  wire logic                 mains_sync_b_i,
    output logic                      firing_output_o,
    output logic                      irq_o,
    output logic                      second_mains_free_o
);
    twp_pkg::twp_core_s s_r;
    twp_pkg::twp_core_s s_nxt;
    logic               rise_a;
    logic               fall_a;
    logic               fall_b;
    logic               tick;
    logic               sync;
    logic               enabled;
    logic               pulse_evt;
    logic               take;
    logic [2:0]         mask;

    function automatic logic hit(input logic [`TWP_ADR_W-1:0] adr,
                                 input logic [`TWP_ADR_W-1:0] off);
        hit = (adr == off);
    endfunction

    twp_edge u_edge (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .a_i      (mains_sync_a_i),
        .b_i      (mains_sync_b_i),
        .tie_i    (s_r.mode[`TWP_BIT_SECOND_MAINS_SOURCE]),
        .rise_a_o (rise_a),
        .fall_a_o (fall_a),
        .fall_b_o (fall_b)
    );

    // half-period sync: rise of a, or fall of b (which is fall of a when tied)
    assign sync    = rise_a | fall_b;
    assign enabled = s_r.mode[`TWP_BIT_REL] & s_r.mode[`TWP_BIT_RUN]
                   & s_r.mode[`TWP_BIT_PHASE];
    assign take    = wb_i.cyc & wb_i.stb & ~s_r.ack;
    assign mask    = s_r.gcf[`TWP_MASK_HI:`TWP_MASK_LO];

    twp_prescaler u_pre (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .clear_i (sync),
        .event_i (s_r.mode[`TWP_BIT_CLOCK_SOURCE_SELECT] ? rise_a : 1'b1),
        .div_i   ({s_r.psh, s_r.psl}),
        .tick_o  (tick)
    );

    always_comb begin
        s_nxt     = s_r;
        pulse_evt = 1'b0;
        s_nxt.ack = take;
        // register writes land on the edge that raises ack
        if (take && wb_i.we && wb_i.sel[0]) begin
            if (hit(wb_i.adr, `TWP_ADR_MODE)) s_nxt.mode = wb_i.dat[7:0];
            if (hit(wb_i.adr, `TWP_ADR_WHI))  s_nxt.whi  = wb_i.dat[7:0];
            if (hit(wb_i.adr, `TWP_ADR_WLO))  s_nxt.wlo  = wb_i.dat[7:0];
            if (hit(wb_i.adr, `TWP_ADR_CNT))  s_nxt.cnt  = wb_i.dat[7:0];
            if (hit(wb_i.adr, `TWP_ADR_PSL))  s_nxt.psl  = wb_i.dat[7:0];
            if (hit(wb_i.adr, `TWP_ADR_PSH))  s_nxt.psh  = wb_i.dat[7:0];
            if (hit(wb_i.adr, `TWP_ADR_GCF))  s_nxt.gcf  = wb_i.dat[7:0];
        end
        s_nxt.rdat = '0;
        if (take) begin
            unique case (wb_i.adr)
                `TWP_ADR_MODE: s_nxt.rdat[7:0] = s_r.mode;
                `TWP_ADR_WHI:  s_nxt.rdat[7:0] = s_r.whi;
                `TWP_ADR_WLO:  s_nxt.rdat[7:0] = s_r.wlo;
                `TWP_ADR_CNT:  s_nxt.rdat[7:0] = s_r.cnt;
                `TWP_ADR_PSL:  s_nxt.rdat[7:0] = s_r.psl;
                `TWP_ADR_PSH:  s_nxt.rdat[7:0] = s_r.psh;
                `TWP_ADR_GCF:  s_nxt.rdat[7:0] = s_r.gcf;
                `TWP_ADR_STAT: s_nxt.rdat[7:0] = {s_r.halves, s_r.state};
                default:       s_nxt.rdat      = '0;
            endcase
        end

        // width is sampled only under peripheral reset so a running train never tears
        if (!s_r.mode[`TWP_BIT_REL]) begin
            s_nxt.width = {s_r.whi, s_r.wlo};
        end

        if (!enabled) begin
            s_nxt.state  = twp_pkg::TWP_IDLE;
            s_nxt.level  = 1'b0;
            s_nxt.halves = '0;
        end else if (sync) begin
            s_nxt.state = twp_pkg::TWP_DELAY;
            s_nxt.delay = s_r.cnt;
            s_nxt.level = 1'b0;
        end else begin
            unique case (s_r.state)
                twp_pkg::TWP_IDLE: begin
                    s_nxt.state = twp_pkg::TWP_IDLE;
                end
                twp_pkg::TWP_DONE: begin
                    s_nxt.state = twp_pkg::TWP_DONE;
                end
                twp_pkg::TWP_DELAY: begin
                    if (s_r.delay == '0) begin
                        pulse_evt    = 1'b1;
                        s_nxt.halves = '0;
                        s_nxt.half   = s_r.width;
                        if (s_r.width == '0) begin
                            s_nxt.state = twp_pkg::TWP_DONE;
                            s_nxt.level = 1'b0;
                        end else begin
                            s_nxt.state = twp_pkg::TWP_PULSE;
                            s_nxt.level = 1'b1;
                        end
                    end else if (tick) begin
                        s_nxt.delay = s_r.delay - 8'h01;
                    end
                end
                twp_pkg::TWP_PULSE: begin
                    if (s_r.half == `TWP_ONE16) begin
                        s_nxt.half   = s_r.width;
                        s_nxt.halves = s_r.halves + 4'h1;
                        s_nxt.level  = ~s_r.level;
                        if (s_r.halves == `TWP_LAST_HALF) begin
                            s_nxt.state = twp_pkg::TWP_DONE;
                            s_nxt.level = 1'b0;
                        end
                    end else begin
                        s_nxt.half = s_r.half - `TWP_ONE16;
                    end
                end
                default: begin
                    s_nxt.state = twp_pkg::TWP_IDLE;
                    s_nxt.level = 1'b0;
                end
            endcase
        end

        // sources all run regardless of mask; only the selection reaches irq
        unique case (mask)
            `TWP_INT_RISE_A: s_nxt.irq = rise_a;
            `TWP_INT_FALL_B: s_nxt.irq = fall_b;
            `TWP_INT_BOTH_A: s_nxt.irq = rise_a | fall_a;
            `TWP_INT_PULSE:  s_nxt.irq = pulse_evt;
            default:         s_nxt.irq = 1'b0;
        endcase
        // polarity acts at once, even mid-pulse
        s_nxt.out = s_nxt.level ^ s_nxt.mode[`TWP_BIT_POL];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r       <= '0;
            s_r.mode  <= `TWP_MODE_RST;
            s_r.wlo   <= `TWP_WLO_RST;
            s_r.whi   <= `TWP_WHI_RST;
            s_r.state <= twp_pkg::TWP_IDLE;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    assign ack_o               = s_r.ack;
    assign dat_o               = s_r.rdat;
    assign firing_output_o     = s_r.out;
    assign irq_o               = s_r.irq;
    assign second_mains_free_o = s_r.mode[`TWP_BIT_SECOND_MAINS_SOURCE];

    AST_ACK_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
        (ack_o && ce_i) |=> !ack_o)
        else $error("ack held longer than one cycle");
    AST_RESET_VAL: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> (s_r.mode == 8'h00 && s_r.wlo == 8'h00 && !firing_output_o))
        else $error("mode or width low not zero after reset");
    AST_POLARITY: assert property (@(posedge clk_i) disable iff (rst_i)
        firing_output_o == (s_r.level ^ s_r.mode[0]))
        else $error("firing output polarity wrong");
    AST_ZERO_WIDTH: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_r.width == 16'h0000) |-> !s_r.level)
        else $error("pulse driven with zero width");
    AST_DISABLED_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && (!s_r.mode[7] || !s_r.mode[5] || !s_r.mode[3]))
            |=> (s_r.state == twp_pkg::TWP_IDLE && !s_r.level))
        else $error("generator active while stopped or held");
    AST_PULSE_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
        ($past(s_r.state) == twp_pkg::TWP_DELAY && $past(ce_i) && $past(!sync)
            && $past(enabled) && $past(mask) == 3'h4
            && s_r.state != twp_pkg::TWP_DELAY) |-> irq_o)
        else $error("first pulse event missing");
    AST_EIGHTH_END: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && enabled && !sync && s_r.state == twp_pkg::TWP_PULSE
            && s_r.halves == 4'hf && s_r.half == 16'h0001)
            |=> (s_r.state == twp_pkg::TWP_DONE && !s_r.level))
        else $error("train not ended after sixteen halves");
    AST_HALF_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && enabled && !sync && s_r.state == twp_pkg::TWP_PULSE
            && s_r.half != 16'h0001) |=> $stable(s_r.level))
        else $error("pulse half cut short");
    AST_WIDTH_FROZEN: assert property (@(posedge clk_i) disable iff (rst_i)
        s_r.mode[7] |=> $stable(s_r.width))
        else $error("width changed while peripheral running");
    AST_T1_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && enabled && sync) |=> (s_r.state == twp_pkg::TWP_DELAY
            && s_r.delay == $past(s_r.cnt)))
        else $error("delay not reloaded at sync");
endmodule
`default_nettype wire

// *** twp_mains_model.sv ***
// mains zero-crossing detector model driving both sync lines
`timescale 1ns/10ps
`default_nettype none
module twp_mains_model #(
    parameter int P = 400
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      mains_sync_a_o,
    output logic      mains_sync_b_o
);
    int cnt;
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 0;
            mains_sync_a_o <= 1'b0;
            mains_sync_b_o <= 1'b0;
        end else begin
            cnt <= (cnt == P - 1) ? 0 : cnt + 1;
            // a falls late and b rises early so that their other edges stay apart
            mains_sync_a_o <= (cnt < 3 * P / 4);
            mains_sync_b_o <= (cnt >= P / 4) && (cnt < P / 2);
        end
    end
endmodule
`default_nettype wire

// *** twp_driver_tb.sv ***
// self-checking bench of the triac firing driver
`timescale 1ns/10ps
`default_nettype none
`include "twp_params.svh"
module twp_driver_tb;
    // short delay and width keep both trains inside each half-period
    localparam int P  = 400;
    localparam int C  = 4;
    localparam int N  = 1;
    // window count starts at the sync edge; output is registered, then seen one edge later
    localparam int D1 = C * (N + 1) + 2;
    localparam int NIRQ [8] = '{0, 1, 1, 2, 2, 0, 0, 0};
    localparam int IDLY [8] = '{0, 1, P / 2 + 1, 1, D1, 0, 0, 0};
    localparam logic [7:0] IDLE_M [4] = '{8'ha0, 8'ha4, 8'h8c, 8'h2c};
    typedef struct packed {
        logic [15:0] tog;
        logic [15:0] first;
        logic [15:0] nsame;
        logic [15:0] dly;
        logic [15:0] idly;
        logic [15:0] nirq;
        logic        lvl;
        logic        free;
    } twp_tb_win_s;

    logic                 clk_i;
    logic                 rst_i = 1'b1;
    twp_pkg::twp_wb_req_s wb    = '0;
    logic                 ack;
    logic [31:0]          dat;
    logic                 sa;
    logic                 sb;
    logic                 fire;
    logic                 irq;
    logic                 free;
    int                   n_mismatch   = 0;
    int                   total_checks = 0;
    logic [31:0]          seed         = 32'h6fad317c;
    logic [31:0]          rq [$];
    twp_tb_win_s          wq [$];
    twp_tb_win_s          acc          = '0;
    logic                 arm          = 1'b0;
    logic                 win          = 1'b0;
    logic                 ap           = 1'b0;
    logic                 fp           = 1'b0;
    int                   t            = 0;
    int                   tl           = 0;

    twp_driver dut (
        .clk_i               (clk_i),
        .rst_i               (rst_i),
        .ce_i                (1'b1),
        .wb_i                (wb),
        .ack_o               (ack),
        .dat_o               (dat),
        .mains_sync_a_i      (sa),
        .mains_sync_b_i      (sb),
        .firing_output_o     (fire),
        .irq_o               (irq),
        .second_mains_free_o (free)
    );
    twp_mains_model #(.P(P)) mains (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .mains_sync_a_o (sa),
        .mains_sync_b_o (sb)
    );

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic compare(input logic [97:0] got, input logic [97:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic twp_tb_win_s ex(input int tg, fs, ns, dl, il, ni, input logic lv, fr);
        return {16'(tg), 16'(fs), 16'(ns), 16'(dl), 16'(il), 16'(ni), lv, fr};
    endfunction

    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d,
                       input logic [31:0] e);
        int i;
        wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
        if (!we) rq.push_back(e);
        for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk_i);
        if (ack !== 1'b1) begin
            n_mismatch++;
            tally_and_finish;
        end
        wb.cyc <= 1'b0;
        wb.stb <= 1'b0;
        @(posedge clk_i);
    endtask

    // width only taken while the peripheral is held in reset
    task automatic setup(input logic [7:0] mode, input logic [7:0] w, input logic [2:0] m);
        bus(1'b1, `TWP_ADR_MODE, {24'h0, mode & 8'h7f}, 32'h0);
        bus(1'b1, `TWP_ADR_WLO, {24'h0, w}, 32'h0);
        bus(1'b1, `TWP_ADR_GCF, {26'h0, m, 3'h0}, 32'h0);
        bus(1'b1, `TWP_ADR_MODE, {24'h0, mode}, 32'h0);
    endtask

    task automatic frame(input twp_tb_win_s e);
        int i;
        wq.push_back(e);
        arm = 1'b1;
        for (i = 0; i < 3 * P && wq.size() > 0; i++) @(posedge clk_i);
        if (wq.size() > 0) begin
            n_mismatch++;
            tally_and_finish;
        end
    endtask

    // one window spans a whole mains period, from one rise of a to the next
    always @(posedge clk_i) begin
        if (ack === 1'b1 && wb.we === 1'b0 && rq.size() > 0) compare(98'(dat), 98'(rq.pop_front()));
        t++;
        if (fire !== fp) begin
            acc.tog++;
            if (acc.tog == 1) acc.dly = 16'(t);
            else if (acc.tog == 2) acc.first = 16'(t - tl);
            if (acc.tog > 1 && t - tl == acc.first) acc.nsame++;
            tl = t;
        end
        if (irq === 1'b1) begin
            acc.nirq++;
            if (acc.nirq == 1) acc.idly = 16'(t);
        end
        fp = fire;
        if (sa === 1'b1 && ap === 1'b0) begin
            if (win && wq.size() > 0) begin
                acc.lvl = fire;
                acc.free = free;
                compare(acc, wq.pop_front());
            end
            win = arm;
            arm = 1'b0;
            acc = '0;
            t = 0;
        end
        ap = sa;
    end

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    initial begin
        int i;
        logic [31:0] r;
        logic [7:0] adr_t [4];
        adr_t = '{`TWP_ADR_WHI, `TWP_ADR_CNT, `TWP_ADR_PSL, `TWP_ADR_PSH};
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b0, `TWP_ADR_MODE, 32'h0, {24'h0, `TWP_MODE_RST});
        bus(1'b0, `TWP_ADR_WLO, 32'h0, {24'h0, `TWP_WLO_RST});
        bus(1'b0, `TWP_ADR_WHI, 32'h0, {24'h0, `TWP_WHI_RST});
        bus(1'b1, `TWP_ADR_STAT, 32'hff, 32'h0);
        bus(1'b0, `TWP_ADR_STAT, 32'h0, 32'h1);
        bus(1'b0, 8'h20, 32'h0, 32'h0);
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            bus(1'b1, adr_t[i], r, 32'h0);
            bus(1'b0, adr_t[i], 32'h0, {24'h0, r[7:0]});
        end
        bus(1'b1, `TWP_ADR_WHI, 32'h0, 32'h0);
        bus(1'b1, `TWP_ADR_CNT, 32'(C), 32'h0);
        bus(1'b1, `TWP_ADR_PSL, 32'(N), 32'h0);
        bus(1'b1, `TWP_ADR_PSH, 32'h0, 32'h0);
        for (i = 0; i < 8; i++) begin
            setup(8'hac, 8'h05, 3'(i));
            frame(ex(32, 5, 30, D1, IDLY[i], NIRQ[i], 1'b0, 1'b0));
        end
        setup(8'hac, 8'h05, 3'h4);
        bus(1'b1, `TWP_ADR_WLO, 32'h9, 32'h0);
        frame(ex(32, 5, 30, D1, D1, 2, 1'b0, 1'b0));
        setup(8'hac, 8'h09, 3'h4);
        frame(ex(32, 9, 30, D1, D1, 2, 1'b0, 1'b0));
        setup(8'hac, 8'h00, 3'h4);
        frame(ex(0, 0, 0, 0, D1, 2, 1'b0, 1'b0));
        setup(8'had, 8'h05, 3'h4);
        frame(ex(32, 5, 30, D1, D1, 2, 1'b1, 1'b0));
        for (i = 0; i < 4; i++) begin
            setup(IDLE_M[i], 8'h05, 3'h4);
            frame(ex(0, 0, 0, 0, 0, 0, 1'b0, 1'b0));
        end
        setup(8'ha8, 8'h05, 3'h4);
        frame(ex(32, 5, 30, D1, D1, 2, 1'b0, 1'b0));
        // mains-a clocking: T1 spans mains periods, every sync restarts it, so no train
        setup(8'hbc, 8'h05, 3'h4);
        frame(ex(0, 0, 0, 0, 0, 0, 1'b0, 1'b0));
        setup(8'he8, 8'h05, 3'h2);
        frame(ex(32, 5, 30, D1, 3 * P / 4 + 1, 1, 1'b0, 1'b1));
        tally_and_finish;
    end
endmodule
`default_nettype wire
